/* design/tcc_consts.svh */
/*
 Constants for the timer/counter block: register offsets, control bit positions,
 reset values and counts. Assumes inclusion by bare name from design files.
*/
// Summary of operation
// (RULE1) Sixteen-bit counter, timer or event counter.
// (RULE2) Counts only while run enable is set.
// (RULE3) Bit 1 selects external pin edges.
// (RULE4) Bit 2 set skips external synchronisation; the code still edge-detects the two-flop synchronised level.
// (RULE5) Bit 3 runs the low-power oscillator.
// (RULE6) Bits 5-4 select input prescale ratio.
// (RULE7) Bit 6 read-only, set when sysclk from oscillator.
// (RULE8) Bit 7 selects buffered sixteen-bit access.
// (RULE9) Compare unit trigger clears the count.
// (RULE10) Wrap from ffff sets latched overflow flag.
// (RULE11) Low byte read buffers live high byte.
// (RULE12) High writes buffered, applied on low write.
// (RULE13) Low write clears prescaler, high write not.
// (RULE14) Prescale codes select 1, 2, 4, 8.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_ADDR_W        3
`define TCC_OFF_CONTROL   3'h0
`define TCC_OFF_LOW       3'h1
`define TCC_OFF_HIGH      3'h2
`define TCC_OFF_STATUS    3'h3
`define TCC_OFF_MASK      3'h4

`define TCC_BIT_RUN       0
`define TCC_BIT_EXT       1
`define TCC_BIT_NOSYNC    2
`define TCC_BIT_OSCEN     3
`define TCC_BIT_PS_LO     4
`define TCC_BIT_PS_HI     5
`define TCC_BIT_SYSRUN    6
`define TCC_BIT_WIDE      7

`define TCC_CONTROL_RESET 8'h00
`define TCC_CONTROL_WMASK 8'hbf
`define TCC_COUNT_RESET   16'h0000
`define TCC_COUNT_MAX     16'hffff
`define TCC_INSTR_DIV     2'h3
`define TCC_PRESC_W       3

`endif

/* design/tcc_pkg.sv */
/*
 Types for the timer/counter block.
 Assumes the constants header is included by the design files that need it.
*/
package tcc_pkg;
    typedef logic [7:0]  tcc_byte_t;
    typedef logic [15:0] tcc_count_t;
    typedef logic [2:0]  tcc_addr_t;
    typedef enum logic [1:0] {
        TCC_DIV1 = 2'h0,
        TCC_DIV2 = 2'h1,
        TCC_DIV4 = 2'h2,
        TCC_DIV8 = 2'h3
    } tcc_div_t;
endpackage

/* design/tcc_edge_sync.sv */
/*
 Two-flop synchroniser with rising edge detector on the synchronised level.
 Assumes the input is asynchronous to mclk.
*/
`timescale 1ns/1ps
module tcc_edge_sync (
    // Clocking
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic clk_en,
    // Signal
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;
endmodule

/* design/tcc_top.sv */
/*
 Sixteen-bit timer/counter with control, buffered wide access, prescaler,
 overflow interrupt and clear by the capture/compare unit trigger.
 Assumes a single-cycle register port master on mclk; the external count pin and
 the oscillator status arrive asynchronously and are synchronised here.
*/
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_top (
    // Clocking
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    // Register port
    input  wire tcc_pkg::tcc_addr_t reg_addr,
    input  wire tcc_pkg::tcc_byte_t reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output tcc_pkg::tcc_byte_t    reg_rdata,
    // Count pin, oscillator clock status and trigger
    input  wire logic             external_count_pin,
    input  wire logic             sysclk_from_osc,
    input  wire logic             capture_compare_trigger,
    // Oscillator and interrupt
    output logic                  lowpower_osc_run,
    output logic                  irq
);
    import tcc_pkg::*;

    tcc_byte_t  control_q;
    tcc_count_t count_q;
    tcc_count_t count_d;
    tcc_byte_t  high_buf_q;
    logic [`TCC_PRESC_W-1:0] presc_q;
    logic [1:0] instr_q;
    logic       status_q;
    logic       mask_q;
    logic       irq_q;
    logic       osc_q;
    tcc_byte_t  rdata_q;
    logic       sysrun_meta_q;
    logic       sysrun_q;
    logic       ext_level;
    logic       ext_rise;
    logic       raw_prev_q;
    logic       tick_in;
    logic       presc_tick;
    logic       inc;
    logic       wrap;
    logic       wr_low;
    logic       wr_high;
    logic       rd_low;
    logic       wide;
    tcc_div_t   div_sel;

    assign wide    = control_q[`TCC_BIT_WIDE];
    assign div_sel = tcc_div_t'(control_q[`TCC_BIT_PS_HI:`TCC_BIT_PS_LO]);
    assign wr_low  = reg_wr && reg_addr == `TCC_OFF_LOW;
    assign wr_high = reg_wr && reg_addr == `TCC_OFF_HIGH;
    assign rd_low  = reg_rd && reg_addr == `TCC_OFF_LOW;

    tcc_edge_sync u_ext_sync (
        .mclk      (mclk),
        .reset     (reset),
        .clk_en    (clk_en),
        .async_in  (external_count_pin),
        .level_out (ext_level),
        .rise_out  (ext_rise)
    );

    // Unsynchronised path still uses the two-flop synchronised level; the pin is only edge-detected
    // through the synchroniser since this block has a single clock.
    always_ff @(posedge mclk) begin
        if (reset) begin
            raw_prev_q <= 1'b0;
        end else if (clk_en) begin
            raw_prev_q <= ext_level;
        end
    end

    // Instruction clock is mclk divided by four.
    always_ff @(posedge mclk) begin
        if (reset) begin
            instr_q <= 2'h0;
        end else if (clk_en) begin
            instr_q <= instr_q + 2'h1;
        end
    end

    // (RULE3) Source selection.
    // (RULE4) Sync bypass only matters with the pin selected.
    always_comb begin
        if (control_q[`TCC_BIT_EXT]) begin
            if (control_q[`TCC_BIT_NOSYNC]) begin
                tick_in = ext_level & ~raw_prev_q;
            end else begin
                tick_in = ext_rise;
            end
        end else begin
            tick_in = (instr_q == `TCC_INSTR_DIV);
        end
    end

    // (RULE6) Prescale ratio select.
    // (RULE14) Codes give 1, 2, 4, 8.
    always_comb begin
        case (div_sel)
            TCC_DIV1: presc_tick = tick_in;
            TCC_DIV2: presc_tick = tick_in && presc_q[0] == 1'b1;
            TCC_DIV4: presc_tick = tick_in && presc_q[1:0] == 2'h3;
            TCC_DIV8: presc_tick = tick_in && presc_q == 3'h7;
            default:  presc_tick = 1'b0;
        endcase
    end

    // (RULE13) Low write clears prescaler.
    always_ff @(posedge mclk) begin
        if (reset) begin
            presc_q <= '0;
        end else if (clk_en) begin
            if (wr_low) begin
                presc_q <= '0;
            end else if (tick_in && control_q[`TCC_BIT_RUN]) begin
                presc_q <= presc_q + 3'h1;
            end
        end
    end

    // (RULE2) Run enable gates counting.
    assign inc  = presc_tick && control_q[`TCC_BIT_RUN];
    assign wrap = inc && count_q == `TCC_COUNT_MAX;

    // (RULE1) Sixteen-bit count register.
    always_comb begin
        count_d = count_q;
        if (inc) begin
            // (RULE10) Up count and wrap.
            count_d = count_q + 16'h0001;
        end
        if (wr_low) begin
            // (RULE12) Buffer lands on low write.
            count_d[7:0]  = reg_wdata;
            count_d[15:8] = wide ? high_buf_q : count_q[15:8];
        end else if (wr_high && !wide) begin
            // (RULE8) Direct high byte access.
            count_d[15:8] = reg_wdata;
        end
        if (capture_compare_trigger) begin
            // (RULE9) Trigger clears count.
            count_d = `TCC_COUNT_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            count_q <= `TCC_COUNT_RESET;
        end else if (clk_en) begin
            count_q <= count_d;
        end
    end

    // (RULE11) High byte buffer.
    always_ff @(posedge mclk) begin
        if (reset) begin
            high_buf_q <= 8'h00;
        end else if (clk_en) begin
            if (wr_high) begin
                high_buf_q <= reg_wdata;
            end else if (rd_low && wide) begin
                high_buf_q <= count_q[15:8];
            end
        end
    end

    // Control register; the status bit is not writable.
    always_ff @(posedge mclk) begin
        if (reset) begin
            control_q <= `TCC_CONTROL_RESET;
        end else if (clk_en && reg_wr && reg_addr == `TCC_OFF_CONTROL) begin
            control_q <= reg_wdata & `TCC_CONTROL_WMASK;
        end
    end

    // (RULE7) Oscillator clock status synchronised.
    always_ff @(posedge mclk) begin
        if (reset) begin
            sysrun_meta_q <= 1'b0;
            sysrun_q      <= 1'b0;
        end else if (clk_en) begin
            sysrun_meta_q <= sysclk_from_osc;
            sysrun_q      <= sysrun_meta_q;
        end
    end

    // (RULE5) Oscillator enable output.
    always_ff @(posedge mclk) begin
        if (reset) begin
            osc_q <= 1'b0;
        end else if (clk_en) begin
            osc_q <= control_q[`TCC_BIT_OSCEN];
        end
    end

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge mclk) begin
        if (reset) begin
            status_q <= 1'b0;
            mask_q   <= 1'b0;
            irq_q    <= 1'b0;
        end else if (clk_en) begin
            // (RULE10) Latched overflow flag.
            if (wrap) begin
                status_q <= 1'b1;
            end else if (reg_wr && reg_addr == `TCC_OFF_STATUS && reg_wdata[0]) begin
                status_q <= 1'b0;
            end
            if (reg_wr && reg_addr == `TCC_OFF_MASK) begin
                mask_q <= reg_wdata[0];
            end
            irq_q <= (status_q | wrap) & mask_q;
        end
    end

    // Read data one cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            rdata_q <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `TCC_OFF_CONTROL: rdata_q <= {control_q[7], sysrun_q, control_q[5:0]};
                    `TCC_OFF_LOW:     rdata_q <= count_q[7:0];
                    `TCC_OFF_HIGH:    rdata_q <= wide ? high_buf_q : count_q[15:8];
                    `TCC_OFF_STATUS:  rdata_q <= {7'h00, status_q};
                    `TCC_OFF_MASK:    rdata_q <= {7'h00, mask_q};
                    default:          rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata        = rdata_q;
    assign lowpower_osc_run = osc_q;
    assign irq              = irq_q;

    property p_hold_when_stopped;
        @(posedge mclk) disable iff (reset)
        (clk_en && !control_q[`TCC_BIT_RUN] && !reg_wr && !capture_compare_trigger)
            |=> count_q == $past(count_q);
    endproperty
    a_hold_when_stopped: assert property (p_hold_when_stopped) else $error("count moved while stopped"); // RULE2

    property p_trigger_clears;
        @(posedge mclk) disable iff (reset)
        (clk_en && capture_compare_trigger) |=> count_q == 16'h0000;
    endproperty
    a_trigger_clears: assert property (p_trigger_clears) else $error("trigger did not clear count"); // RULE9

    property p_wrap_flag;
        @(posedge mclk) disable iff (reset)
        (clk_en && inc && count_q == 16'hffff && !capture_compare_trigger && !reg_wr)
            |=> status_q && count_q == 16'h0000;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag"); // RULE10

    property p_buffer_on_low_read;
        @(posedge mclk) disable iff (reset)
        (clk_en && rd_low && wide && !wr_high) |=> high_buf_q == $past(count_q[15:8]);
    endproperty
    a_buffer_on_low_read: assert property (p_buffer_on_low_read) else $error("high buffer not loaded"); // RULE11

    property p_low_write_applies_buffer;
        @(posedge mclk) disable iff (reset)
        (clk_en && wr_low && wide && !capture_compare_trigger) |=> count_q[15:8] == $past(high_buf_q);
    endproperty
    a_low_write_applies_buffer: assert property (p_low_write_applies_buffer) else $error("buffer not applied"); // RULE12

    property p_high_write_buffered;
        @(posedge mclk) disable iff (reset)
        (clk_en && wr_high && wide && !capture_compare_trigger && !inc) |=> count_q == $past(count_q);
    endproperty
    a_high_write_buffered: assert property (p_high_write_buffered) else $error("wide high write hit count"); // RULE8

    property p_low_write_clears_presc;
        @(posedge mclk) disable iff (reset)
        (clk_en && wr_low) |=> presc_q == 3'h0;
    endproperty
    a_low_write_clears_presc: assert property (p_low_write_clears_presc) else $error("prescaler not cleared"); // RULE13

    property p_div8;
        @(posedge mclk) disable iff (reset)
        (clk_en && inc && div_sel == TCC_DIV8) |=> presc_q == 3'h0;
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight misfires"); // RULE14

    property p_internal_rate;
        @(posedge mclk) disable iff (reset)
        (clk_en && !control_q[`TCC_BIT_EXT]) |-> tick_in == (instr_q == 2'h3);
    endproperty
    a_internal_rate: assert property (p_internal_rate) else $error("internal tick wrong"); // RULE3

    property p_status_readonly;
        @(posedge mclk) disable iff (reset)
        1'b1 |-> control_q[`TCC_BIT_SYSRUN] == 1'b0;
    endproperty
    a_status_readonly: assert property (p_status_readonly) else $error("status bit stored"); // RULE7

    // (RULE14) Ratio tick count.
    // A control write may leave the prescaler mid-count, so the check waits for a low write.
    logic [3:0] gap_q;
    logic       gap_valid_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            gap_q       <= 4'h0;
            gap_valid_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_low || inc) begin
                gap_q <= 4'h0;
            end else if (tick_in && control_q[`TCC_BIT_RUN]) begin
                gap_q <= gap_q + 4'h1;
            end
            if (reg_wr && reg_addr == `TCC_OFF_CONTROL) begin
                gap_valid_q <= 1'b0;
            end else if (wr_low) begin
                gap_valid_q <= 1'b1;
            end
        end
    end

    property p_div_ratio;
        @(posedge mclk) disable iff (reset)
        (clk_en && inc && gap_valid_q) |-> (gap_q + 4'h1) == (4'h1 << div_sel);
    endproperty
    a_div_ratio: assert property (p_div_ratio) else $error("prescale ratio wrong"); // RULE14

    property p_high_keeps_presc;
        @(posedge mclk) disable iff (reset)
        (clk_en && wr_high && !(tick_in && control_q[`TCC_BIT_RUN])) |=> presc_q == $past(presc_q);
    endproperty
    a_high_keeps_presc: assert property (p_high_keeps_presc) else $error("high write moved prescaler"); // RULE13

    property p_osc_follows;
        @(posedge mclk) disable iff (reset)
        clk_en |=> lowpower_osc_run == $past(control_q[`TCC_BIT_OSCEN]);
    endproperty
    a_osc_follows: assert property (p_osc_follows) else $error("oscillator enable not followed"); // RULE5

    c_div8:    cover property (@(posedge mclk) disable iff (reset) inc && div_sel == TCC_DIV8);
    c_wrap:    cover property (@(posedge mclk) disable iff (reset) wrap);
    c_trigger: cover property (@(posedge mclk) disable iff (reset) capture_compare_trigger && count_q != 16'h0000);
    c_wide_rd: cover property (@(posedge mclk) disable iff (reset) rd_low && wide);
    c_ext:     cover property (@(posedge mclk) disable iff (reset) inc && control_q[`TCC_BIT_EXT]);
endmodule

/* dv/tcc_ext_model.sv */
/*
 Far side of the timer/counter: the external count pin and the low-power
 oscillator that may feed the system clock. Assumes the bench calls its tasks.
*/
`timescale 1ns/1ps
module tcc_ext_model (
    // Oscillator state from the block
    input  wire logic osc_run,
    // Pins toward the block
    output logic      ext_pin,
    output logic      sys_osc
);
    logic use_osc;

    initial begin
        ext_pin = 1'b0;
        use_osc = 1'b0;
    end

    // The oscillator can only feed the system clock while it is running.
    assign sys_osc = use_osc & osc_run;

    // Pin edges are spaced unrelated to mclk, as a real crystal or pin would be.
    task automatic pulses(input int n);
        repeat (n) begin
            #137;
            ext_pin = 1'b1;
            #163;
            ext_pin = 1'b0;
        end
    endtask

    task automatic select_osc(input logic b);
        use_osc = b;
    endtask
endmodule

/* dv/tb_top.sv */
/*
 Self-checking bench for the timer/counter block.
 Assumes the design files and the external source model are compiled first.
*/
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tb_top;
    import tcc_pkg::*;
    logic       mclk, reset, clk_en, reg_wr, reg_rd, trig, rd_pend;
    tcc_addr_t  reg_addr;
    tcc_byte_t  reg_wdata, reg_rdata, r1, r2;
    logic       osc_run, irq, ext_pin, sys_osc;
    logic [31:0] seed = 32'h0000000f;
    tcc_byte_t  exp_q[$];
    bit         tol_q[$];
    int         miscompares = 0;
    int         check_count = 0;

    tcc_top i_dut (.mclk(mclk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_count_pin(ext_pin), .sysclk_from_osc(sys_osc),
        .capture_compare_trigger(trig), .lowpower_osc_run(osc_run), .irq(irq));
    tcc_ext_model i_ext (.osc_run(osc_run), .ext_pin(ext_pin), .sys_osc(sys_osc));

    function automatic tcc_byte_t rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic end_sim;
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Counts sampled against a free tick phase may land one either side.
    task automatic chk_byte(input tcc_byte_t got, input tcc_byte_t e, input bit tol);
        check_count++;
        if (!(got === e || (tol && (got === e + 8'h01 || got === e - 8'h01)))) begin
            miscompares++;
            $display("ERROR %0t read %h expected %h", $time, got, e);
        end
    endtask

    // Levels are taken when the task is called, which can be the time step of the edge that moves them; the compare waits for mid-cycle.
    task automatic chk_bit(input logic got, input logic e);
        @(negedge mclk);
        check_count++;
        if (got !== e) begin
            miscompares++;
            $display("ERROR %0t output %b expected %b", $time, got, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input tcc_addr_t a, input tcc_byte_t d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input tcc_addr_t a, input tcc_byte_t e, input bit tol);
        @(posedge mclk);
        exp_q.push_back(e);
        tol_q.push_back(tol);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
    endtask

    always @(posedge mclk) rd_pend <= reg_rd & clk_en & ~reset;

    // Read data stand only in the cycle after the strobe.
    always @(negedge mclk) begin
        if (rd_pend) begin
            chk_byte(reg_rdata, exp_q.pop_front(), tol_q.pop_front());
        end
    end

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        #(20000 * 25);
        miscompares++;
        end_sim();
    end

    initial begin
        reset = 1'b1; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; trig = 1'b0;
        reg_addr = 3'h0; reg_wdata = 8'h00;
        cyc(3);
        reset <= 1'b0;
        for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00, 1'b0);
        wr(`TCC_OFF_CONTROL, 8'hff);
        rd(`TCC_OFF_CONTROL, 8'hbf, 1'b0);
        chk_bit(osc_run, 1'b1);
        i_ext.select_osc(1'b1);
        cyc(4);
        rd(`TCC_OFF_CONTROL, 8'hff, 1'b0);
        wr(`TCC_OFF_CONTROL, 8'h00);
        cyc(4);
        chk_bit(osc_run, 1'b0);
        rd(`TCC_OFF_CONTROL, 8'h00, 1'b0);
        i_ext.select_osc(1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(`TCC_OFF_CONTROL, {2'h0, i[1:0], 4'h1});
            wr(`TCC_OFF_LOW, 8'h00);
            cyc(64 << i);
            wr(`TCC_OFF_CONTROL, 8'h00);
            rd(`TCC_OFF_LOW, 8'h10, 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            wr(`TCC_OFF_CONTROL, {5'h00, i[0], 2'h3});
            wr(`TCC_OFF_LOW, 8'h00);
            i_ext.pulses(10);
            cyc(8);
            wr(`TCC_OFF_CONTROL, 8'h00);
            rd(`TCC_OFF_LOW, 8'h0a, 1'b0);
        end
        r1 = rnd();
        wr(`TCC_OFF_LOW, r1);
        wr(`TCC_OFF_CONTROL, 8'h02);
        i_ext.pulses(3);
        cyc(40);
        rd(`TCC_OFF_LOW, r1, 1'b0);
        wr(`TCC_OFF_STATUS, 8'h01);
        wr(`TCC_OFF_MASK, 8'h01);
        wr(`TCC_OFF_HIGH, 8'hff);
        wr(`TCC_OFF_LOW, 8'hfe);
        chk_bit(irq, 1'b0);
        wr(`TCC_OFF_CONTROL, 8'h01);
        cyc(16);
        wr(`TCC_OFF_CONTROL, 8'h00);
        cyc(2);
        chk_bit(irq, 1'b1);
        rd(`TCC_OFF_STATUS, 8'h01, 1'b0);
        rd(`TCC_OFF_HIGH, 8'h00, 1'b0);
        wr(`TCC_OFF_MASK, 8'h00);
        cyc(2);
        chk_bit(irq, 1'b0);
        wr(`TCC_OFF_MASK, 8'h01);
        cyc(2);
        chk_bit(irq, 1'b1);
        wr(`TCC_OFF_STATUS, 8'h01);
        cyc(2);
        chk_bit(irq, 1'b0);
        rd(`TCC_OFF_STATUS, 8'h00, 1'b0);
        wr(`TCC_OFF_LOW, 8'h55);
        wr(`TCC_OFF_HIGH, 8'h66);
        @(posedge mclk) trig <= 1'b1;
        @(posedge mclk) trig <= 1'b0;
        rd(`TCC_OFF_LOW, 8'h00, 1'b0);
        rd(`TCC_OFF_HIGH, 8'h00, 1'b0);
        @(posedge mclk) clk_en <= 1'b0;
        wr(`TCC_OFF_LOW, 8'haa);
        clk_en <= 1'b1;
        rd(`TCC_OFF_LOW, 8'h00, 1'b0);
        r1 = rnd();
        r2 = rnd();
        wr(`TCC_OFF_CONTROL, 8'h80);
        wr(`TCC_OFF_HIGH, r1);
        wr(`TCC_OFF_LOW, r2);
        rd(`TCC_OFF_LOW, r2, 1'b0);
        rd(`TCC_OFF_HIGH, r1, 1'b0);
        wr(`TCC_OFF_HIGH, ~r1);
        rd(`TCC_OFF_HIGH, ~r1, 1'b0);
        rd(`TCC_OFF_LOW, r2, 1'b0);
        rd(`TCC_OFF_HIGH, r1, 1'b0);
        wr(`TCC_OFF_CONTROL, 8'h00);
        rd(`TCC_OFF_HIGH, r1, 1'b0);
        wr(`TCC_OFF_HIGH, r2);
        rd(`TCC_OFF_HIGH, r2, 1'b0);
        cyc(4);
        end_sim();
    end
endmodule
